// ==== design/ppfm_defines.vh ====
// Register map, field positions and reset values of the port function mux
`ifndef PPFM_DEFINES_VH
`define PPFM_DEFINES_VH

// Register byte offsets (word aligned, Avalon word addresses * 4)
`define PPFM_P1_IN_OFF 8'h00
`define PPFM_P1_OUT_OFF 8'h04
`define PPFM_P1_DIR_OFF 8'h08
`define PPFM_P1_IFG_OFF 8'h0C
`define PPFM_P1_IES_OFF 8'h10
`define PPFM_P1_IE_OFF 8'h14
`define PPFM_P1_SEL_OFF 8'h18
`define PPFM_P2_IN_OFF 8'h20
`define PPFM_P2_OUT_OFF 8'h24
`define PPFM_P2_DIR_OFF 8'h28
`define PPFM_P2_IFG_OFF 8'h2C
`define PPFM_P2_IES_OFF 8'h30
`define PPFM_P2_IE_OFF 8'h34
`define PPFM_P2_SEL_OFF 8'h38
`define PPFM_IRQ_STAT_OFF 8'h3C
`define PPFM_IRQ_MASK_OFF 8'h40

// Widths
`define PPFM_ADDR_W 8
`define PPFM_P1_W 8
`define PPFM_P2_W 3

// Reset values
`define PPFM_RST_BYTE 8'h00
`define PPFM_RST_P2 3'h0

// Summary status bits: pin event of port one, of port two
`define PPFM_STAT_P1_BIT 0
`define PPFM_STAT_P2_BIT 1
`define PPFM_STAT_W 2

`endif

// ==== design/ppfm_pin_irq.v ====
// Per-pin edge detect, interrupt flag and enable gating for one port
`timescale 1ns/10ps
`default_nettype none
module ppfm_pin_irq #(
    parameter W = 8
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // Synchronised pin level and control
    input wire [W-1:0] pin_level_i,
    input wire [W-1:0] pin_edge_select_i,
    input wire [W-1:0] pin_irq_enable_i,
    // Software access to flags
    input wire flag_wr_i,
    input wire [W-1:0] flag_wdata_i,
    // Results
    output wire [W-1:0] pin_irq_flag_o,
    output wire [W-1:0] edge_event_o,
    output wire port_irq_o
);
    reg [W-1:0] last_reg;
    reg [W-1:0] flag_reg;
    reg [W-1:0] flag_next;
    wire [W-1:0] rise;
    wire [W-1:0] fall;
    wire [W-1:0] hit;

    assign rise = pin_level_i & ~last_reg;
    assign fall = ~pin_level_i & last_reg;
    // Edge select 0 picks rising, 1 picks falling
    assign hit = (rise & ~pin_edge_select_i) | (fall & pin_edge_select_i);

    // Set wins over a software write in the same cycle
    always @* begin
        flag_next = flag_reg;
        if (flag_wr_i) begin
            flag_next = flag_wdata_i;
        end
        flag_next = flag_next | hit;
    end

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            last_reg <= {W{1'b0}};
            flag_reg <= {W{1'b0}};
        end else begin
            last_reg <= pin_level_i;
            flag_reg <= flag_next;
        end
    end

    assign pin_irq_flag_o = flag_reg;
    assign edge_event_o = hit;
    assign port_irq_o = |(flag_reg & pin_irq_enable_i);
endmodule // ppfm_pin_irq
`default_nettype wire

// ==== design/ppfm_port.v ====
// Top: port one and port two pin logic with Avalon-MM register slave
`timescale 1ns/10ps
`default_nettype none
`include "ppfm_defines.vh"
module ppfm_port #(
    parameter P1_W = `PPFM_P1_W,
    parameter P2_W = `PPFM_P2_W
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // Avalon-MM slave
    input wire [`PPFM_ADDR_W-1:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    output reg [31:0] avs_readdata_o,
    output wire avs_waitrequest_o,
    // Port one pads
    input wire [P1_W-1:0] p1_pad_in_i,
    output wire [P1_W-1:0] p1_pad_out_o,
    output wire [P1_W-1:0] p1_pad_oe_o,
    // Port two pads
    input wire [P2_W-1:0] p2_pad_in_i,
    output wire [P2_W-1:0] p2_pad_out_o,
    output wire [P2_W-1:0] p2_pad_oe_o,
    // Timer, clock and comparator module signals
    input wire timer_compare_output_0_i,
    input wire timer_compare_output_1_i,
    input wire timer_compare_output_2_i,
    input wire sub_system_clock_i,
    input wire aux_clock_i,
    input wire comparator_output_i,
    output wire timer_external_clock_in_o,
    output wire capture_input0_option_a_o,
    output wire capture_input1_option_a_o,
    output wire capture_input2_option_a_o,
    output wire capture_input0_option_b_o,
    output wire timer_alternate_clock_in_o,
    // Interrupts
    output wire p1_irq_o,
    output wire p2_irq_o,
    output wire irq_o
);
    // Control registers
    reg [P1_W-1:0] p1_out_reg;
    reg [P1_W-1:0] p1_dir_reg;
    reg [P1_W-1:0] p1_ies_reg;
    reg [P1_W-1:0] p1_ie_reg;
    reg [P1_W-1:0] p1_sel_reg;
    reg [P2_W-1:0] p2_out_reg;
    reg [P2_W-1:0] p2_dir_reg;
    reg [P2_W-1:0] p2_ies_reg;
    reg [P2_W-1:0] p2_ie_reg;
    reg [P2_W-1:0] p2_sel_reg;
    reg [`PPFM_STAT_W-1:0] stat_reg;
    reg [`PPFM_STAT_W-1:0] stat_next;
    reg [`PPFM_STAT_W-1:0] mask_reg;
    reg ack_reg;
    reg [31:0] rdata_next;

    wire [P1_W-1:0] p1_in;
    wire [P2_W-1:0] p2_in;
    wire [P1_W-1:0] p1_flag;
    wire [P2_W-1:0] p2_flag;
    wire [P1_W-1:0] p1_evt;
    wire [P2_W-1:0] p2_evt;
    wire [P1_W-1:0] p1_mod_out;
    wire [P2_W-1:0] p2_mod_out;
    wire req;
    wire wr_en;
    wire rd_en;
    wire p1_flag_wr;
    wire p2_flag_wr;

    // Byte lane 0 carries every register; upper lanes ignored
    function wr_hit;
        input [`PPFM_ADDR_W-1:0] addr;
        input [`PPFM_ADDR_W-1:0] off;
        begin
            wr_hit = wr_en && (addr == off) && avs_byteenable_i[0];
        end
    endfunction

    // One wait state: request seen, answered the next edge
    assign req = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = req & ~ack_reg;
    assign wr_en = avs_write_i & ~ack_reg;
    assign rd_en = avs_read_i & ~ack_reg;

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req & ~ack_reg;
        end
    end

    // Pads are asynchronous to clk_i
    ppfm_sync2 #(.W(P1_W)) u_sync_p1 (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .async_i(p1_pad_in_i),
        .sync_o(p1_in)
    );

    ppfm_sync2 #(.W(P2_W)) u_sync_p2 (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .async_i(p2_pad_in_i),
        .sync_o(p2_in)
    );

    // Module outputs per pin
    assign p1_mod_out = {timer_compare_output_2_i,
                         timer_compare_output_1_i,
                         timer_compare_output_0_i,
                         sub_system_clock_i,
                         timer_compare_output_2_i,
                         timer_compare_output_1_i,
                         timer_compare_output_0_i,
                         1'b0};
    assign p2_mod_out = {comparator_output_i, 1'b0, aux_clock_i};

    // Direction from the direction bit alone, no module overrides it
    assign p1_pad_oe_o = p1_dir_reg;
    assign p2_pad_oe_o = p2_dir_reg;
    // Clock outputs pass combinationally; registering would halve them
    assign p1_pad_out_o = (p1_sel_reg & p1_mod_out) |
                          (~p1_sel_reg & p1_out_reg);
    assign p2_pad_out_o = (p2_sel_reg & p2_mod_out) |
                          (~p2_sel_reg & p2_out_reg);

    // Module inputs, gated by the function select
    assign timer_external_clock_in_o = p1_sel_reg[0] & p1_in[0];
    assign capture_input0_option_a_o = p1_sel_reg[1] & p1_in[1];
    assign capture_input1_option_a_o = p1_sel_reg[2] & p1_in[2];
    assign capture_input2_option_a_o = p1_sel_reg[3] & p1_in[3];
    assign timer_alternate_clock_in_o = p2_sel_reg[1] & p2_in[1];
    assign capture_input0_option_b_o = p2_sel_reg[2] & p2_in[2];

    assign p1_flag_wr = wr_hit(avs_address_i, `PPFM_P1_IFG_OFF);
    assign p2_flag_wr = wr_hit(avs_address_i, `PPFM_P2_IFG_OFF);

    ppfm_pin_irq #(.W(P1_W)) u_irq_p1 (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .pin_level_i(p1_in),
        .pin_edge_select_i(p1_ies_reg),
        .pin_irq_enable_i(p1_ie_reg),
        .flag_wr_i(p1_flag_wr),
        .flag_wdata_i(avs_writedata_i[P1_W-1:0]),
        .pin_irq_flag_o(p1_flag),
        .edge_event_o(p1_evt),
        .port_irq_o(p1_irq_o)
    );

    ppfm_pin_irq #(.W(P2_W)) u_irq_p2 (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .pin_level_i(p2_in),
        .pin_edge_select_i(p2_ies_reg),
        .pin_irq_enable_i(p2_ie_reg),
        .flag_wr_i(p2_flag_wr),
        .flag_wdata_i(avs_writedata_i[P2_W-1:0]),
        .pin_irq_flag_o(p2_flag),
        .edge_event_o(p2_evt),
        .port_irq_o(p2_irq_o)
    );

    // Summary status: sticky, cleared by read, new event wins
    always @* begin
        stat_next = stat_reg;
        if (rd_en && avs_address_i == `PPFM_IRQ_STAT_OFF) begin
            stat_next = {`PPFM_STAT_W{1'b0}};
        end
        if (|(p1_evt & p1_ie_reg)) begin
            stat_next[`PPFM_STAT_P1_BIT] = 1'b1;
        end
        if (|(p2_evt & p2_ie_reg)) begin
            stat_next[`PPFM_STAT_P2_BIT] = 1'b1;
        end
    end

    assign irq_o = |(stat_reg & mask_reg);

    // Register writes
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            p1_out_reg <= `PPFM_RST_BYTE;
            p1_dir_reg <= `PPFM_RST_BYTE;
            p1_ies_reg <= `PPFM_RST_BYTE;
            p1_ie_reg <= `PPFM_RST_BYTE;
            p1_sel_reg <= `PPFM_RST_BYTE;
            p2_out_reg <= `PPFM_RST_P2;
            p2_dir_reg <= `PPFM_RST_P2;
            p2_ies_reg <= `PPFM_RST_P2;
            p2_ie_reg <= `PPFM_RST_P2;
            p2_sel_reg <= `PPFM_RST_P2;
            stat_reg <= {`PPFM_STAT_W{1'b0}};
            mask_reg <= {`PPFM_STAT_W{1'b0}};
        end else begin
            stat_reg <= stat_next;
            if (wr_hit(avs_address_i, `PPFM_P1_OUT_OFF)) begin
                p1_out_reg <= avs_writedata_i[P1_W-1:0];
            end
            if (wr_hit(avs_address_i, `PPFM_P1_DIR_OFF)) begin
                p1_dir_reg <= avs_writedata_i[P1_W-1:0];
            end
            if (wr_hit(avs_address_i, `PPFM_P1_IES_OFF)) begin
                p1_ies_reg <= avs_writedata_i[P1_W-1:0];
            end
            if (wr_hit(avs_address_i, `PPFM_P1_IE_OFF)) begin
                p1_ie_reg <= avs_writedata_i[P1_W-1:0];
            end
            if (wr_hit(avs_address_i, `PPFM_P1_SEL_OFF)) begin
                p1_sel_reg <= avs_writedata_i[P1_W-1:0];
            end
            if (wr_hit(avs_address_i, `PPFM_P2_OUT_OFF)) begin
                p2_out_reg <= avs_writedata_i[P2_W-1:0];
            end
            if (wr_hit(avs_address_i, `PPFM_P2_DIR_OFF)) begin
                p2_dir_reg <= avs_writedata_i[P2_W-1:0];
            end
            if (wr_hit(avs_address_i, `PPFM_P2_IES_OFF)) begin
                p2_ies_reg <= avs_writedata_i[P2_W-1:0];
            end
            if (wr_hit(avs_address_i, `PPFM_P2_IE_OFF)) begin
                p2_ie_reg <= avs_writedata_i[P2_W-1:0];
            end
            if (wr_hit(avs_address_i, `PPFM_P2_SEL_OFF)) begin
                p2_sel_reg <= avs_writedata_i[P2_W-1:0];
            end
            if (wr_hit(avs_address_i, `PPFM_IRQ_MASK_OFF)) begin
                mask_reg <= avs_writedata_i[`PPFM_STAT_W-1:0];
            end
        end
    end

    // Read mux; unmapped addresses read zero
    always @* begin
        rdata_next = 32'h00000000;
        case (avs_address_i)
            `PPFM_P1_IN_OFF: rdata_next[P1_W-1:0] = p1_in;
            `PPFM_P1_OUT_OFF: rdata_next[P1_W-1:0] = p1_out_reg;
            `PPFM_P1_DIR_OFF: rdata_next[P1_W-1:0] = p1_dir_reg;
            `PPFM_P1_IFG_OFF: rdata_next[P1_W-1:0] = p1_flag;
            `PPFM_P1_IES_OFF: rdata_next[P1_W-1:0] = p1_ies_reg;
            `PPFM_P1_IE_OFF: rdata_next[P1_W-1:0] = p1_ie_reg;
            `PPFM_P1_SEL_OFF: rdata_next[P1_W-1:0] = p1_sel_reg;
            `PPFM_P2_IN_OFF: rdata_next[P2_W-1:0] = p2_in;
            `PPFM_P2_OUT_OFF: rdata_next[P2_W-1:0] = p2_out_reg;
            `PPFM_P2_DIR_OFF: rdata_next[P2_W-1:0] = p2_dir_reg;
            `PPFM_P2_IFG_OFF: rdata_next[P2_W-1:0] = p2_flag;
            `PPFM_P2_IES_OFF: rdata_next[P2_W-1:0] = p2_ies_reg;
            `PPFM_P2_IE_OFF: rdata_next[P2_W-1:0] = p2_ie_reg;
            `PPFM_P2_SEL_OFF: rdata_next[P2_W-1:0] = p2_sel_reg;
            `PPFM_IRQ_STAT_OFF: rdata_next[`PPFM_STAT_W-1:0] = stat_reg;
            `PPFM_IRQ_MASK_OFF: rdata_next[`PPFM_STAT_W-1:0] = mask_reg;
            default: rdata_next = 32'h00000000;
        endcase
    end

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            avs_readdata_o <= 32'h00000000;
        end else if (rd_en) begin
            avs_readdata_o <= rdata_next;
        end
    end
endmodule // ppfm_port
`default_nettype wire

// ==== design/ppfm_sync2.v ====
// Two-flop synchroniser for a vector of pad inputs
`timescale 1ns/10ps
`default_nettype none
module ppfm_sync2 #(
    parameter W = 8
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // Data
    input wire [W-1:0] async_i,
    output wire [W-1:0] sync_o
);
    reg [W-1:0] meta_reg;
    reg [W-1:0] sync_reg;

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta_reg <= {W{1'b0}};
            sync_reg <= {W{1'b0}};
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;
endmodule // ppfm_sync2
`default_nettype wire

// ==== testbench/ppfm_pad_model.sv ====
// Board-side drivers on the pads, yielding wherever the port drives
`timescale 1ns/10ps
`default_nettype none
module ppfm_pad_model #(
    parameter int W = 8
) (
    // Port side
    input wire logic [W-1:0] pad_out_i,
    input wire logic [W-1:0] pad_oe_i,
    // Board side
    input wire logic [W-1:0] ext_level_i,
    output wire logic [W-1:0] pad_level_o
);
    // Board never fights an enabled pad driver
    assign pad_level_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_level_i);
endmodule // ppfm_pad_model
`default_nettype wire

// ==== testbench/ppfm_port_asserts.sv ====
// Port-level checker of the port function mux, bound to its top
`timescale 1ns/10ps
`default_nettype none
`include "ppfm_defines.vh"
module ppfm_port_asserts (
    // Clock, reset and register bus
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    // Pads
    input wire logic [7:0] p1_pad_in_i,
    input wire logic [7:0] p1_pad_out_o,
    input wire logic [7:0] p1_pad_oe_o,
    input wire logic [2:0] p2_pad_in_i,
    input wire logic [2:0] p2_pad_out_o,
    // Module side
    input wire logic timer_compare_output_0_i,
    input wire logic timer_compare_output_1_i,
    input wire logic timer_compare_output_2_i,
    input wire logic sub_system_clock_i,
    input wire logic aux_clock_i,
    input wire logic comparator_output_i,
    input wire logic timer_external_clock_in_o,
    input wire logic capture_input0_option_a_o,
    input wire logic timer_alternate_clock_in_o,
    input wire logic p1_irq_o,
    input wire logic irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    logic [7:0] sel1, out1, dir1;
    logic [2:0] sel2, out2;
    logic mask0;
    wire wr_tk = avs_write_i & avs_waitrequest_o & avs_byteenable_i[0];
    wire [3:0] m = {timer_compare_output_2_i, timer_compare_output_1_i,
                    timer_compare_output_0_i, sub_system_clock_i};
    wire [7:0] mux1 = (sel1 & {m, m[3:1], 1'b0}) | (~sel1 & out1);
    wire [2:0] mux2 = (sel2 & {comparator_output_i, 1'b0, aux_clock_i})
                      | (~sel2 & out2);
    // Shadow copies track writes at the edge the slave takes them
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            {sel1, out1, dir1, sel2, out2, mask0} <= 31'h0;
        end else if (wr_tk) begin
            case (avs_address_i)
                `PPFM_P1_SEL_OFF: sel1 <= avs_writedata_i[7:0];
                `PPFM_P1_OUT_OFF: out1 <= avs_writedata_i[7:0];
                `PPFM_P1_DIR_OFF: dir1 <= avs_writedata_i[7:0];
                `PPFM_P2_SEL_OFF: sel2 <= avs_writedata_i[2:0];
                `PPFM_P2_OUT_OFF: out2 <= avs_writedata_i[2:0];
                `PPFM_IRQ_MASK_OFF: mask0 <= avs_writedata_i[0];
                default: ;
            endcase
        end
    end
    a_p1_pad_mux: assert property (p1_pad_out_o == mux1)
        else $error("port one pad output wrong");
    a_p2_pad_mux: assert property (p2_pad_out_o == mux2)
        else $error("port two pad output wrong");
    a_dir_to_oe: assert property (p1_pad_oe_o == dir1)
        else $error("port one drive enable wrong");
    a_ext_clk_route: assert property (
        $past(rst_n_i) && $past(rst_n_i, 2) |->
        timer_external_clock_in_o == (sel1[0] && $past(p1_pad_in_i[0], 2)))
        else $error("timer clock input wrong");
    a_cap0_route: assert property (
        $past(rst_n_i) && $past(rst_n_i, 2) |->
        capture_input0_option_a_o == (sel1[1] && $past(p1_pad_in_i[1], 2)))
        else $error("capture input zero wrong");
    a_alt_clk_route: assert property (
        $past(rst_n_i) && $past(rst_n_i, 2) |->
        timer_alternate_clock_in_o == (sel2[1] && $past(p2_pad_in_i[1], 2)))
        else $error("alternate clock input wrong");
    a_wait_one: assert property (avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("bus wait longer than one cycle");
    a_irq_from_edge: assert property (
        $rose(p1_irq_o) && !$past(avs_write_i)
        |-> $past(p1_pad_in_i, 3) != $past(p1_pad_in_i, 4))
        else $error("request without pin edge");
    a_irq_mask_path: assert property (
        $rose(p1_irq_o) && mask0 && !$past(avs_write_i) |-> irq_o)
        else $error("unmasked pin request missing");
    a_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o &&
        avs_address_i == 8'h44 |-> avs_readdata_o == 32'h0)
        else $error("unmapped read not zero");
endmodule // ppfm_port_asserts
bind ppfm_port ppfm_port_asserts chk_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .p1_pad_in_i(p1_pad_in_i), .p1_pad_out_o(p1_pad_out_o),
    .p1_pad_oe_o(p1_pad_oe_o), .p2_pad_in_i(p2_pad_in_i),
    .p2_pad_out_o(p2_pad_out_o),
    .timer_compare_output_0_i(timer_compare_output_0_i),
    .timer_compare_output_1_i(timer_compare_output_1_i),
    .timer_compare_output_2_i(timer_compare_output_2_i),
    .sub_system_clock_i(sub_system_clock_i), .aux_clock_i(aux_clock_i),
    .comparator_output_i(comparator_output_i),
    .timer_external_clock_in_o(timer_external_clock_in_o),
    .capture_input0_option_a_o(capture_input0_option_a_o),
    .timer_alternate_clock_in_o(timer_alternate_clock_in_o),
    .p1_irq_o(p1_irq_o), .irq_o(irq_o));
`default_nettype wire

// ==== testbench/ppfm_port_tb_top.sv ====
// Self-checking bench of the port function mux
`timescale 1ns/10ps
`default_nettype none
`include "ppfm_defines.vh"
module ppfm_port_tb_top;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] adr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [3:0] be = 4'hF;
    logic [2:0] cmp = 3'h0;
    logic ssc = 1'b0;
    logic aux = 1'b0;
    logic cmpo = 1'b0;
    logic [7:0] ext1 = 8'h00;
    logic [2:0] ext2 = 3'h0;
    logic [31:0] q;
    wire [31:0] rdat;
    wire wreq, tclk, cap0a, cap1a, cap2a, cap0b, alt, p1_irq, p2_irq, irq;
    wire [7:0] p1_in, p1_out, p1_oe;
    wire [2:0] p2_in, p2_out, p2_oe;
    int num_errors = 0;
    int cmp_count = 0;
    always #2.5 clk_i = ~clk_i;
    ppfm_port dut_u (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
        .avs_byteenable_i(be), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wreq), .p1_pad_in_i(p1_in),
        .p1_pad_out_o(p1_out), .p1_pad_oe_o(p1_oe), .p2_pad_in_i(p2_in),
        .p2_pad_out_o(p2_out), .p2_pad_oe_o(p2_oe),
        .timer_compare_output_0_i(cmp[0]), .timer_compare_output_1_i(cmp[1]),
        .timer_compare_output_2_i(cmp[2]), .sub_system_clock_i(ssc),
        .aux_clock_i(aux), .comparator_output_i(cmpo),
        .timer_external_clock_in_o(tclk), .capture_input0_option_a_o(cap0a),
        .capture_input1_option_a_o(cap1a), .capture_input2_option_a_o(cap2a),
        .capture_input0_option_b_o(cap0b), .timer_alternate_clock_in_o(alt),
        .p1_irq_o(p1_irq), .p2_irq_o(p2_irq), .irq_o(irq));
    ppfm_pad_model #(.W(8)) pm1_u (.pad_out_i(p1_out), .pad_oe_i(p1_oe),
        .ext_level_i(ext1), .pad_level_o(p1_in));
    ppfm_pad_model #(.W(3)) pm2_u (.pad_out_i(p2_out), .pad_oe_i(p2_oe),
        .ext_level_i(ext2), .pad_level_o(p2_in));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Request held until waitrequest is seen low at a rising edge
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        int n;
        n = 0;
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= ~w;
        // Values read here are those just before the edge
        @(posedge clk_i);
        while (wreq !== 1'b0 && n < 50) begin
            n++;
            @(posedge clk_i);
        end
        if (n == 50) num_errors++;
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task automatic end_of_test;
        $display("errors=%0d compares=%0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge clk_i);
        num_errors++;
        end_of_test();
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        for (int a = 0; a <= 8'h44; a += 4) rdc(8'(a), 32'h0);
        xfer(1'b1, 8'h44, 32'hFF);
        rdc(8'h44, 32'h0);
        xfer(1'b1, `PPFM_P1_DIR_OFF, 32'hA5);
        chk({24'h0, p1_oe}, 32'hA5);
        be <= 4'h0;
        xfer(1'b1, `PPFM_P1_DIR_OFF, 32'hFF);
        be <= 4'hF;
        rdc(`PPFM_P1_DIR_OFF, 32'hA5);
        xfer(1'b1, `PPFM_P1_OUT_OFF, 32'h3C);
        chk({24'h0, p1_out}, 32'h3C);
        xfer(1'b1, `PPFM_P1_SEL_OFF, 32'hFF);
        for (int k = 0; k < 16; k++) begin
            {cmp, ssc} <= 4'(k);
            repeat (2) @(posedge clk_i);
            chk({24'h0, p1_out}, {24'h0, 4'(k), 3'(k >> 1), 1'b0});
        end
        xfer(1'b1, `PPFM_P1_DIR_OFF, 32'h00);
        ext1 <= 8'h0F;
        repeat (4) @(posedge clk_i);
        chk({28'h0, cap2a, cap1a, cap0a, tclk}, 32'hF);
        rdc(`PPFM_P1_IN_OFF, 32'h0F);
        chk({31'h0, p1_irq}, 32'h0);
        xfer(1'b1, `PPFM_P1_SEL_OFF, 32'h00);
        chk({28'h0, cap2a, cap1a, cap0a, tclk}, 32'h0);
        xfer(1'b1, `PPFM_P2_DIR_OFF, 32'h7);
        xfer(1'b1, `PPFM_P2_SEL_OFF, 32'h7);
        {aux, cmpo} <= 2'b11;
        repeat (2) @(posedge clk_i);
        chk({29'h0, p2_out}, 32'h5);
        chk({29'h0, p2_oe}, 32'h7);
        xfer(1'b1, `PPFM_P2_DIR_OFF, 32'h0);
        ext2 <= 3'h6;
        repeat (4) @(posedge clk_i);
        chk({30'h0, cap0b, alt}, 32'h3);
        xfer(1'b1, `PPFM_P1_IFG_OFF, 32'h0);
        ext1 <= 8'h00;
        repeat (4) @(posedge clk_i);
        rdc(`PPFM_P1_IFG_OFF, 32'h0);
        xfer(1'b1, `PPFM_P1_IES_OFF, 32'h02);
        xfer(1'b1, `PPFM_P1_IE_OFF, 32'h01);
        xfer(1'b1, `PPFM_IRQ_MASK_OFF, 32'h1);
        ext1 <= 8'h03;
        repeat (4) @(posedge clk_i);
        chk({29'h0, irq, p2_irq, p1_irq}, 32'h5);
        rdc(`PPFM_P1_IFG_OFF, 32'h01);
        ext1 <= 8'h00;
        repeat (4) @(posedge clk_i);
        rdc(`PPFM_P1_IFG_OFF, 32'h03);
        rdc(`PPFM_IRQ_STAT_OFF, 32'h1);
        chk({30'h0, irq, p1_irq}, 32'h1);
        xfer(1'b1, `PPFM_P1_IFG_OFF, 32'h0);
        chk({31'h0, p1_irq}, 32'h0);
        xfer(1'b1, `PPFM_IRQ_MASK_OFF, 32'h0);
        ext1 <= 8'h01;
        repeat (4) @(posedge clk_i);
        chk({29'h0, irq, p2_irq, p1_irq}, 32'h1);
        rdc(`PPFM_IRQ_STAT_OFF, 32'h1);
        xfer(1'b1, `PPFM_P2_IFG_OFF, 32'h0);
        xfer(1'b1, `PPFM_P2_IES_OFF, 32'h4);
        xfer(1'b1, `PPFM_P2_IE_OFF, 32'h4);
        xfer(1'b1, `PPFM_IRQ_MASK_OFF, 32'h2);
        ext2 <= 3'h2;
        repeat (4) @(posedge clk_i);
        chk({29'h0, irq, p2_irq, p1_irq}, 32'h7);
        rdc(`PPFM_P2_IFG_OFF, 32'h4);
        rdc(`PPFM_IRQ_STAT_OFF, 32'h2);
        chk({31'h0, irq}, 32'h0);
        end_of_test();
    end
endmodule // ppfm_port_tb_top
`default_nettype wire
